// ---- hw/pts_postscaler.v ----
// Four-bit postscaler counting period matches
`timescale 1ns/1ps
`default_nettype none

module pts_postscaler #(
    parameter W = 4
) (
    input  wire         mclk,
    input  wire         reset,
    input  wire         clear,
    input  wire         match,
    input  wire [W-1:0] ratio,
    output reg          done
);

    reg [W-1:0] post_r;

    // Divide matches by ratio plus one
    always @(posedge mclk) begin
        if (reset || clear) begin
            post_r <= {W{1'b0}};
            done   <= 1'b0;
        end else begin
            done <= 1'b0;
            if (match) begin
                if (post_r >= ratio) begin
                    post_r <= {W{1'b0}};
                    done   <= 1'b1;
                end else begin
                    post_r <= post_r + {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule // pts_postscaler

`default_nettype wire

// ---- hw/pts_prescaler.v ----
// Instruction clock divider and selectable input prescaler
`timescale 1ns/1ps
`default_nettype none
`include "pts_defs.vh"

module pts_prescaler (
    input  wire       mclk,
    input  wire       reset,
    input  wire       clear,
    input  wire       run,
    input  wire [1:0] sel,
    output reg        tick
);

    reg  [1:0] phase_r;
    reg  [3:0] pre_r;
    reg  [3:0] term;
    wire       iclk_en;

    // Decode divide ratio; both upper codes give 1:16
    always @* begin
        case (sel)
            2'h0:    term = `PTS_PRE_DIV1;
            2'h1:    term = `PTS_PRE_DIV4;
            default: term = `PTS_PRE_DIV16;
        endcase
    end

    assign iclk_en = (phase_r == `PTS_ICLK_DIV);

    // Quarter-rate phase runs free so the cycle grid never slips
    always @(posedge mclk) begin
        if (reset) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end

    // Prescale counter, cleared by reset or by count or control writes
    always @(posedge mclk) begin
        if (reset || clear) begin
            pre_r <= 4'h0;
            tick  <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (run && iclk_en) begin
                if (pre_r >= term) begin
                    pre_r <= 4'h0;
                    tick  <= 1'b1;
                end else begin
                    pre_r <= pre_r + 4'h1;
                end
            end
        end
    end

endmodule // pts_prescaler

`default_nettype wire

// ---- hw/pts_timer.v ----
// Period timer top: APB registers, counter, pre- and postscaler
// Functional notes
// - The timer is an 8-bit up-counter fed by the prescaled instruction clock, with a postscaler on its match.
// - The counter input is the instruction clock divided by 1, 4 or 16 per the prescale select field.
// - Software may read and write the count register at any time.
// - Every reset clears the count register.
// - The count rises from zero to the limit, then returns to zero on the next increment, forming the match.
// - The limit register is read/write and resets to all ones.
// - Matches pass through a 4-bit postscaler whose completion sets the match flag.
// - The counter stops while the run bit, bit 2 of control, is clear.
// - Writes to count or control, and any reset, clear the prescaler and postscaler.
// - Writing the control register leaves the count unchanged.
// - The raw match, before the postscaler, goes to the serial port as a shift clock source.
// - The raw match is the PWM period time base for the capture/compare unit.
`timescale 1ns/1ps
`default_nettype none
`include "pts_defs.vh"

module pts_timer #(
    parameter CW = 8,
    parameter PW = 4
) (
    input  wire        mclk,
    input  wire        reset,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         sync_serial_port_tick,
    output reg         capture_compare_unit_base,
    output reg         period_match_flag
);

    reg  [CW-1:0] period_count_reg_r;
    reg  [CW-1:0] period_count_reg_nxt;
    reg  [CW-1:0] period_limit_reg_r;
    reg  [6:0]    timer_control_reg_r;
    reg           flag_nxt;
    reg  [31:0]   rdata_nxt;
    reg           hit_nxt;
    reg           match_nxt;
    wire          setup;
    wire          wr_count;
    wire          wr_limit;
    wire          wr_ctrl;
    wire          wr_flag;
    wire          scaler_clr;
    wire          pre_tick;
    wire          post_done;
    wire          timer_run_bit;
    wire [1:0]    input_prescale_select;
    wire [PW-1:0] post_ratio;

    // Decode in the setup phase; every access answers in the next cycle
    assign setup    = psel && !penable;
    assign wr_count = setup && pwrite && (paddr == `PTS_ADDR_COUNT);
    assign wr_limit = setup && pwrite && (paddr == `PTS_ADDR_LIMIT);
    assign wr_ctrl  = setup && pwrite && (paddr == `PTS_ADDR_CTRL);
    assign wr_flag  = setup && pwrite && (paddr == `PTS_ADDR_FLAG);

    // Writes to count or control restart both scalers
    assign scaler_clr = wr_count || wr_ctrl;

    // Control fields
    assign timer_run_bit         = timer_control_reg_r[`PTS_CTRL_RUN];
    assign input_prescale_select =
        timer_control_reg_r[`PTS_CTRL_PRE_HI:`PTS_CTRL_PRE_LO];
    assign post_ratio =
        timer_control_reg_r[`PTS_CTRL_POST_HI:`PTS_CTRL_POST_LO];

    // Prescaler gates the counter; it stops with the run bit
    pts_prescaler u_pre (
        .mclk  (mclk),
        .reset (reset),
        .clear (scaler_clr),
        .run   (timer_run_bit),
        .sel   (input_prescale_select),
        .tick  (pre_tick)
    );

    // Postscaler on the raw match
    pts_postscaler #(
        .W (PW)
    ) u_post (
        .mclk  (mclk),
        .reset (reset),
        .clear (scaler_clr),
        .match (match_nxt),
        .ratio (post_ratio),
        .done  (post_done)
    );

    // Count next value; a software write wins over an increment
    always @* begin
        period_count_reg_nxt = period_count_reg_r;
        hit_nxt              = (period_count_reg_r == period_limit_reg_r);
        match_nxt            = 1'b0;
        if (wr_count) begin
            period_count_reg_nxt = pwdata[CW-1:0];
        end else if (pre_tick && timer_run_bit) begin
            if (hit_nxt) begin
                period_count_reg_nxt = {CW{1'b0}};
                match_nxt            = 1'b1;
            end else begin
                period_count_reg_nxt = period_count_reg_r +
                                       {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    // Count and limit storage; control writes leave the count alone
    always @(posedge mclk) begin
        if (reset) begin
            period_count_reg_r  <= `PTS_COUNT_RST;
            period_limit_reg_r  <= `PTS_LIMIT_RST;
            timer_control_reg_r <= `PTS_CTRL_RST;
        end else begin
            period_count_reg_r <= period_count_reg_nxt;
            if (wr_limit) begin
                period_limit_reg_r <= pwdata[CW-1:0];
            end
            if (wr_ctrl) begin
                timer_control_reg_r <= pwdata[6:0];
            end
        end
    end

    // Flag: postscaler completion wins over a clear in the same cycle
    always @* begin
        flag_nxt = period_match_flag;
        if (wr_flag && !pwdata[`PTS_FLAG_BIT]) begin
            flag_nxt = 1'b0;
        end
        if (post_done) begin
            flag_nxt = 1'b1;
        end
    end

    // Read mux; unused bits read as zero
    always @* begin
        rdata_nxt = 32'h0000_0000;
        case (paddr)
            `PTS_ADDR_COUNT: rdata_nxt[CW-1:0] = period_count_reg_r;
            `PTS_ADDR_LIMIT: rdata_nxt[CW-1:0] = period_limit_reg_r;
            `PTS_ADDR_CTRL:  rdata_nxt[6:0]    = timer_control_reg_r;
            `PTS_ADDR_FLAG:  rdata_nxt[`PTS_FLAG_BIT] = period_match_flag;
            default:         rdata_nxt = 32'h0000_0000;
        endcase
    end

    // APB answer one cycle after setup; unmapped addresses error
    always @(posedge mclk) begin
        if (reset) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && (paddr != `PTS_ADDR_COUNT) &&
                       (paddr != `PTS_ADDR_LIMIT) &&
                       (paddr != `PTS_ADDR_CTRL) &&
                       (paddr != `PTS_ADDR_FLAG);
            if (setup && !pwrite) begin
                prdata <= rdata_nxt;
            end
        end
    end

    // Registered outputs: flag and the raw match to its consumers
    always @(posedge mclk) begin
        if (reset) begin
            period_match_flag         <= 1'b0;
            sync_serial_port_tick     <= 1'b0;
            capture_compare_unit_base <= 1'b0;
        end else begin
            period_match_flag         <= flag_nxt;
            sync_serial_port_tick     <= match_nxt;
            capture_compare_unit_base <= match_nxt;
        end
    end

endmodule // pts_timer

`default_nettype wire

// ---- pkg/pts_defs.vh ----
// Constants for the period timer with pre- and postscaler
`ifndef PTS_DEFS_VH
`define PTS_DEFS_VH

// Register byte addresses on the APB slave
`define PTS_ADDR_COUNT   12'h000
`define PTS_ADDR_LIMIT   12'h004
`define PTS_ADDR_CTRL    12'h008
`define PTS_ADDR_FLAG    12'h00C

// Control register fields
`define PTS_CTRL_PRE_LO  0
`define PTS_CTRL_PRE_HI  1
`define PTS_CTRL_RUN     2
`define PTS_CTRL_POST_LO 3
`define PTS_CTRL_POST_HI 6

// Flag register field
`define PTS_FLAG_BIT     1

// Reset values
`define PTS_COUNT_RST    8'h00
`define PTS_LIMIT_RST    8'hFF
`define PTS_CTRL_RST     7'h00

// Instruction clock is the core clock divided by four
`define PTS_ICLK_DIV     2'h3

// Prescale terminal counts (ratio minus one)
`define PTS_PRE_DIV1     4'h0
`define PTS_PRE_DIV4     4'h3
`define PTS_PRE_DIV16    4'hF

`endif

// ---- tb/pts_timer_assertions.sv ----
// Concurrent checks on the period timer ports
`timescale 1ns/1ps
`default_nettype none
module pts_timer_assertions #(
    parameter CW = 8,
    parameter PW = 4
) (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sync_serial_port_tick,
    input wire logic        capture_compare_unit_base,
    input wire logic        period_match_flag
);
    // One domain; reset mutes all but the reset check
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (reset);
    AST_ANSWER: assert property (psel && !penable |=> pready)
        else $error("setup not answered");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("ready too long");
    // Only the four mapped words answer cleanly; any other address errors
    AST_ERR: assert property (pready |-> pslverr ==
        !(paddr == 12'h000 || paddr == 12'h004 ||
          paddr == 12'h008 || paddr == 12'h00C))
        else $error("error flag wrong");
    AST_SAME: assert property (sync_serial_port_tick ==
        capture_compare_unit_base) else $error("time bases differ");
    // Instruction clock is a quarter of mclk, so matches are spaced
    AST_SPACE: assert property (sync_serial_port_tick |=>
        !sync_serial_port_tick [*3]) else $error("matches too close");
    AST_FLAG_SET: assert property ($rose(period_match_flag)
        |-> $past(sync_serial_port_tick)) else $error("flag without match");
    AST_FLAG_HOLD: assert property ($fell(period_match_flag) |->
        $past(psel && !penable && pwrite && paddr == 12'h00C && !pwdata[1]))
        else $error("flag dropped on its own");
    AST_RESET: assert property (disable iff (1'b0) reset |=>
        !pready && !sync_serial_port_tick && !period_match_flag)
        else $error("reset left outputs active");
endmodule // pts_timer_assertions
bind pts_timer pts_timer_assertions #(.CW(CW), .PW(PW)) u_chk (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .sync_serial_port_tick(sync_serial_port_tick),
    .capture_compare_unit_base(capture_compare_unit_base),
    .period_match_flag(period_match_flag)
);
`default_nettype wire

// ---- tb/test_pts_timer.sv ----
// Self-checking bench for the period timer
`timescale 1ns/1ps
`default_nettype none
`include "pts_defs.vh"
module test_pts_timer;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         tick;
    wire         flag;
    logic [32:0] exp_q[$];
    logic [7:0]  v;
    logic [7:0]  l;
    integer      err_count = 0;
    integer      num_checks = 0;
    integer      i, j, c, n;
    time         t0;

    // Core clock, 10 ns period
    always #5 mclk = ~mclk;

    pts_timer pts_timer_inst (
        .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sync_serial_port_tick(tick),
        .capture_compare_unit_base(), .period_match_flag(flag)
    );

    task automatic chk(input logic [32:0] s, input logic [32:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task end_of_test;
        if (err_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Idle edge before setup: no signal gets two writes in one step
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        integer k;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            err_count++;
            end_of_test;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask

    task wait_tick;
        integer k;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (tick !== 1'b1 && k < 2000);
        if (tick !== 1'b1) begin
            err_count++;
            end_of_test;
        end
    endtask

    // Count raw matches until the flag rises; bounded, a hang fails
    task count_to_flag;
        c = 0;
        for (i = 0; i < 400 && flag !== 1'b1; i++) begin
            @(posedge mclk);
            if (tick === 1'b1) c++;
        end
        if (flag !== 1'b1) begin
            err_count++;
            end_of_test;
        end
    endtask

    task rst;
        reset <= 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
    endtask

    // Each read answer against the oldest note, error bit on top
    always @(posedge mclk)
        if (psel && penable && pready && !pwrite && exp_q.size() > 0)
            chk({pslverr, prdata}, exp_q.pop_front());

    initial begin
        void'($urandom(6));
        rst;
        rd(`PTS_ADDR_COUNT, 33'h0);
        rd(`PTS_ADDR_LIMIT, 33'hFF);
        rd(`PTS_ADDR_CTRL, 33'h0);
        rd(12'h010, 33'h100000000);
        v = 8'($urandom);
        l = 8'($urandom % 4 + 1);
        wr(`PTS_ADDR_COUNT, {24'h0, v});
        wr(`PTS_ADDR_LIMIT, {24'h0, l});
        rd(`PTS_ADDR_LIMIT, {25'h0, l});
        repeat (100) @(posedge mclk);
        rd(`PTS_ADDR_COUNT, {25'h0, v});
        wr(`PTS_ADDR_CTRL, 32'h3);
        rd(`PTS_ADDR_COUNT, {25'h0, v});
        // Match spacing for every prescale code
        for (i = 0; i < 4; i++) begin
            wr(`PTS_ADDR_COUNT, 32'h0);
            wr(`PTS_ADDR_CTRL, 32'h4 | i);
            wait_tick;
            t0 = $time;
            wait_tick;
            n = (i == 0) ? 1 : (i == 1) ? 4 : 16;
            chk(33'(($time - t0) / 10), 33'(4 * n * (l + 1)));
        end
        // Postscale ratios: plain, random, widest
        wr(`PTS_ADDR_LIMIT, 32'h0);
        for (j = 0; j < 3; j++) begin
            n = (j == 0) ? 0 : (j == 1) ? $urandom % 16 : 15;
            wr(`PTS_ADDR_CTRL, 32'h0);
            wr(`PTS_ADDR_FLAG, 32'h0);
            wr(`PTS_ADDR_COUNT, 32'h0);
            wr(`PTS_ADDR_CTRL, 32'(4 + 8 * n));
            count_to_flag;
            chk(33'(c), 33'(n + 1));
        end
        wr(`PTS_ADDR_CTRL, 32'h0);
        rd(`PTS_ADDR_FLAG, 33'h2);
        wr(`PTS_ADDR_FLAG, 32'h2);
        rd(`PTS_ADDR_FLAG, 33'h2);
        wr(`PTS_ADDR_FLAG, 32'h0);
        rd(`PTS_ADDR_FLAG, 33'h0);
        // Control rewrite after one match restarts the 1:2 postscaler
        wr(`PTS_ADDR_CTRL, 32'hC);
        wait_tick;
        wr(`PTS_ADDR_CTRL, 32'hC);
        count_to_flag;
        chk(33'(c), 33'h2);
        rst;
        rd(`PTS_ADDR_COUNT, 33'h0);
        rd(`PTS_ADDR_LIMIT, 33'hFF);
        @(posedge mclk);
        end_of_test;
    end
endmodule // test_pts_timer
`default_nettype wire
